// ### shared/asp_map.svh
/*
  offsets, field positions, reset values and timing counts of the serial port.
  assumes a 10 MHz system clock and a byte-addressed wishbone slave.
*/
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH

`define ASP_CLK_HZ 10000000
`define ASP_OVS 8
`define ASP_DEF_BAUD 9600
`define ASP_DEF_DIV (`ASP_CLK_HZ / (`ASP_OVS * `ASP_DEF_BAUD))

`define ASP_OFF_DATA 8'h00
`define ASP_OFF_STAT 8'h04
`define ASP_OFF_CTRL 8'h08
`define ASP_OFF_BAUD 8'h0c
`define ASP_OFF_IRQ 8'h10
`define ASP_OFF_MASK 8'h14

`define ASP_CTRL_DATA8 0
`define ASP_CTRL_PAR_EN 1
`define ASP_CTRL_PAR_ODD 2
`define ASP_CTRL_STOP2 3
`define ASP_CTRL_FLOW 4
`define ASP_CTRL_RTS 5
`define ASP_CTRL_DTR 6
`define ASP_CTRL_WAKE_EN 7
`define ASP_CTRL_RESET 8'h11

`define ASP_ST_TX_BUSY 0
`define ASP_ST_RX_VALID 1
`define ASP_ST_CTS 2
`define ASP_ST_DCD 3
`define ASP_ST_RING 4
`define ASP_ST_DRV_EN 5
`define ASP_ST_TX_PEND 6

`define ASP_IRQ_RX_DONE 0
`define ASP_IRQ_TX_DONE 1
`define ASP_IRQ_PAR_ERR 2
`define ASP_IRQ_FRM_ERR 3
`define ASP_IRQ_OVERRUN 4
`define ASP_IRQ_RING 5
`define ASP_IRQ_DCD_CHG 6
`define ASP_IRQ_CTS_CHG 7

`endif

// ### shared/asp_pkg.sv
/*
  types shared by the serial port modules.
  assumes asp_map.svh supplies the numeric constants.
*/
package asp_pkg;
  typedef enum logic {ASP_FLOW_NONE, ASP_FLOW_RTSCTS} asp_flow_type;
  typedef enum logic [2:0] {TX_IDLE, TX_LEAD, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_TAIL} asp_tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asp_rx_state_type;
endpackage

// ### src/asp_tx.sv
/*
  transmitter: frames one character per take, drives the line driver enable.
  assumes tick_i pulses eight times per bit and cts_ok_i is already synchronised.
*/
`timescale 1ns/100ps
`include "asp_map.svh"
module asp_tx (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic [7:0] data_i,
  input wire logic pend_i,
  input wire logic cts_ok_i,
  input wire logic data8_i,
  input wire logic par_en_i,
  input wire logic par_odd_i,
  input wire logic stop2_i,
  output logic take_o,
  output logic done_o,
  output logic busy_o,
  output logic txd_o,
  output logic drv_en_o
);
  asp_pkg::asp_tx_state_type state_r;
  logic [2:0] sub_r;
  logic [2:0] bit_r;
  logic [7:0] shift_r;
  logic par_r, data8_r, par_en_r, par_odd_r, stop2_r;
  logic bit_end, stop_last, load;

  assign bit_end = tick_i && (sub_r == 3'h7);
  assign stop_last = bit_end && (!stop2_r || bit_r == 3'h1);
  // a queued character follows the stop bit directly, so the driver stays on;
  // from idle the take waits for a tick so the lead is exactly one bit long
  assign load = pend_i && cts_ok_i && ((state_r == asp_pkg::TX_IDLE && tick_i) ||
                (state_r == asp_pkg::TX_STOP && stop_last));
  assign busy_o = (state_r != asp_pkg::TX_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i || state_r == asp_pkg::TX_IDLE || load) begin
      sub_r <= 3'h0;
    end else if (tick_i) begin
      sub_r <= sub_r + 3'h1;
    end
  end

  // frame format is frozen per character so a mid-frame write cannot tear it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data8_r <= 1'b1;
      par_en_r <= 1'b0;
      par_odd_r <= 1'b0;
      stop2_r <= 1'b0;
    end else if (load) begin
      data8_r <= data8_i;
      par_en_r <= par_en_i;
      par_odd_r <= par_odd_i;
      stop2_r <= stop2_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= asp_pkg::TX_IDLE;
      txd_o <= 1'b1;
      drv_en_o <= 1'b0;
      take_o <= 1'b0;
      done_o <= 1'b0;
      bit_r <= 3'h0;
      shift_r <= 8'h00;
      par_r <= 1'b0;
    end else begin
      take_o <= load;
      done_o <= (state_r == asp_pkg::TX_STOP) && stop_last;
      if (load) begin
        shift_r <= data_i;
        par_r <= 1'b0;
        bit_r <= 3'h0;
      end
      unique case (state_r)
        asp_pkg::TX_IDLE: begin
          if (load) begin
            state_r <= asp_pkg::TX_LEAD;
            drv_en_o <= 1'b1;
          end
        end
        asp_pkg::TX_LEAD: begin
          if (bit_end) begin
            state_r <= asp_pkg::TX_START;
            txd_o <= 1'b0;
          end
        end
        asp_pkg::TX_START: begin
          if (bit_end) begin
            state_r <= asp_pkg::TX_DATA;
            txd_o <= shift_r[0];
            par_r <= shift_r[0];
            shift_r <= {1'b0, shift_r[7:1]};
          end
        end
        asp_pkg::TX_DATA: begin
          if (bit_end) begin
            if (bit_r == (data8_r ? 3'h7 : 3'h6)) begin
              bit_r <= 3'h0;
              if (par_en_r) begin
                state_r <= asp_pkg::TX_PAR;
                txd_o <= par_r ^ par_odd_r;
              end else begin
                state_r <= asp_pkg::TX_STOP;
                txd_o <= 1'b1;
              end
            end else begin
              bit_r <= bit_r + 3'h1;
              txd_o <= shift_r[0];
              par_r <= par_r ^ shift_r[0];
              shift_r <= {1'b0, shift_r[7:1]};
            end
          end
        end
        asp_pkg::TX_PAR: begin
          if (bit_end) begin
            state_r <= asp_pkg::TX_STOP;
            txd_o <= 1'b1;
          end
        end
        asp_pkg::TX_STOP: begin
          if (load) begin
            state_r <= asp_pkg::TX_START;
            txd_o <= 1'b0;
          end else if (stop_last) begin
            state_r <= asp_pkg::TX_TAIL;
          end else if (bit_end) begin
            bit_r <= 3'h1;
          end
        end
        asp_pkg::TX_TAIL: begin
          if (bit_end) begin
            state_r <= asp_pkg::TX_IDLE;
            drv_en_o <= 1'b0;
          end
        end
      endcase
    end
  end
endmodule // asp_tx

// ### src/asp_rx.sv
/*
  receiver: finds the start edge on eight-fold oversampling, samples bit centres.
  assumes rxd_i has been through a two-stage synchroniser.
*/
`timescale 1ns/100ps
`include "asp_map.svh"
module asp_rx (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic rxd_i,
  input wire logic data8_i,
  input wire logic par_en_i,
  input wire logic par_odd_i,
  output logic [7:0] data_o,
  output logic done_o,
  output logic par_err_o,
  output logic frm_err_o
);
  asp_pkg::asp_rx_state_type state_r;
  logic [2:0] sub_r;
  logic [2:0] bit_r;
  logic [7:0] shift_r;
  logic par_r, perr_r, centre;

  assign centre = tick_i && (sub_r == 3'h7);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= asp_pkg::RX_IDLE;
      sub_r <= 3'h0;
      bit_r <= 3'h0;
      shift_r <= 8'h00;
      par_r <= 1'b0;
      perr_r <= 1'b0;
      data_o <= 8'h00;
      done_o <= 1'b0;
      par_err_o <= 1'b0;
      frm_err_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (tick_i) begin
        sub_r <= sub_r + 3'h1;
      end
      unique case (state_r)
        asp_pkg::RX_IDLE: begin
          sub_r <= 3'h0;
          if (tick_i && !rxd_i) begin
            state_r <= asp_pkg::RX_START;
            sub_r <= 3'h1;
          end
        end
        asp_pkg::RX_START: begin
          // a glitch shorter than three eighths of a bit is dropped here
          if (tick_i && sub_r == 3'h3) begin
            sub_r <= 3'h0;
            bit_r <= 3'h0;
            par_r <= 1'b0;
            perr_r <= 1'b0;
            state_r <= rxd_i ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
          end
        end
        asp_pkg::RX_DATA: begin
          if (centre) begin
            shift_r <= {rxd_i, shift_r[7:1]};
            par_r <= par_r ^ rxd_i;
            bit_r <= bit_r + 3'h1;
            if (bit_r == (data8_i ? 3'h7 : 3'h6)) begin
              state_r <= par_en_i ? asp_pkg::RX_PAR : asp_pkg::RX_STOP;
            end
          end
        end
        asp_pkg::RX_PAR: begin
          if (centre) begin
            perr_r <= rxd_i ^ par_r ^ par_odd_i;
            state_r <= asp_pkg::RX_STOP;
          end
        end
        asp_pkg::RX_STOP: begin
          if (centre) begin
            state_r <= asp_pkg::RX_IDLE;
            data_o <= data8_i ? shift_r : {1'b0, shift_r[7:1]};
            done_o <= 1'b1;
            par_err_o <= perr_r;
            frm_err_o <= !rxd_i;
          end
        end
      endcase
    end
  end
endmodule // asp_rx

// ### src/asp_top.sv
/*
  asynchronous serial port with modem-style flow control and a line driver enable,
  reached over a classic wishbone slave with one level interrupt.
  assumes a single 10 MHz clock; all modem and serial inputs are asynchronous pins.
*/
// Functional notes
// - the bit rate is set by a divider and covers 19 baud up to the top rate.
// - the top rate is the clock divided by 8, reached with a divider of one.
// - a frame is a low start bit, 7 or 8 data bits, optional parity and 1 or 2 stop bits.
// - data bits travel least significant first.
// - out of reset the port runs 9600 baud, 8 data bits, no parity, 1 stop bit, all writable.
// - out of reset the port uses request/clear-to-send flow control, selectable by software.
// - the line driver enable rises one bit time before the first start bit.
// - the line driver enable falls one bit time after the last stop bit.
// - the line driver enable stays high through the whole transmission.
// - send_request_n is driven and send_clear_n is sampled to pace the two parties.
// - terminal_ready_n is driven by software and carrier_detect_n is readable by it.
// - an asserted ring_indicate_n raises the wake output when software enables it.
`timescale 1ns/100ps
`include "asp_map.svh"
module asp_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic send_request_n_o,
  input wire logic send_clear_n_i,
  output logic terminal_ready_n_o,
  input wire logic carrier_detect_n_i,
  input wire logic ring_indicate_n_i,
  output logic line_driver_enable_o,
  output logic irq_o,
  output logic wake_o
);
  localparam logic [15:0] DEF_DIV = 16'(`ASP_DEF_DIV);

  logic [7:0] ctrl_r;
  logic [15:0] div_r;
  logic [15:0] cnt_r;
  logic tick_r;
  logic [7:0] irq_st_r;
  logic [7:0] irq_mask_r;
  logic [7:0] irq_ev;
  logic [7:0] tx_hold_r;
  logic tx_pend_r;
  logic [7:0] rx_data_r;
  logic rx_valid_r;
  logic [3:0] pin_raw;
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic [3:0] prev_r;
  logic rxd_s, cts_s, dcd_s, ring_s;
  logic req, acc_wr, acc_rd;
  logic [31:0] rd_mux;
  logic [7:0] reg_sel;
  logic cts_ok;
  logic tx_take, tx_done, tx_busy;
  logic [7:0] rx_byte;
  logic rx_done, rx_perr, rx_ferr;
  asp_pkg::asp_flow_type flow;

  assign flow = asp_pkg::asp_flow_type'(ctrl_r[`ASP_CTRL_FLOW]);

  // every pin passes two flops; the second stage is read, and a third flop prev_r feeds the edge events
  assign pin_raw = {ring_indicate_n_i, carrier_detect_n_i, send_clear_n_i, serial_in_i};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_r[gi] <= 1'b1;
          sync_r[gi] <= 1'b1;
          prev_r[gi] <= 1'b1;
        end else begin
          meta_r[gi] <= pin_raw[gi];
          sync_r[gi] <= meta_r[gi];
          prev_r[gi] <= sync_r[gi];
        end
      end
    end
  endgenerate
  assign rxd_s = sync_r[0];
  assign cts_s = sync_r[1];
  assign dcd_s = sync_r[2];
  assign ring_s = sync_r[3];

  // wishbone: ack one cycle after the request; writes and read side effects
  // land on the acked edge only
  assign req = wb_cyc_i && wb_stb_i;
  assign acc_wr = req && wb_ack_o && wb_we_i;
  assign acc_rd = req && wb_ack_o && !wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      `ASP_OFF_DATA: rd_mux[7:0] = rx_data_r;
      `ASP_OFF_STAT: begin
        rd_mux[`ASP_ST_TX_BUSY] = tx_busy;
        rd_mux[`ASP_ST_RX_VALID] = rx_valid_r;
        rd_mux[`ASP_ST_CTS] = !cts_s;
        rd_mux[`ASP_ST_DCD] = !dcd_s;
        rd_mux[`ASP_ST_RING] = !ring_s;
        rd_mux[`ASP_ST_DRV_EN] = line_driver_enable_o;
        rd_mux[`ASP_ST_TX_PEND] = tx_pend_r;
      end
      `ASP_OFF_CTRL: rd_mux[7:0] = ctrl_r;
      `ASP_OFF_BAUD: rd_mux[15:0] = div_r;
      `ASP_OFF_IRQ: rd_mux[7:0] = irq_st_r;
      `ASP_OFF_MASK: rd_mux[7:0] = irq_mask_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_ack_o && !wb_we_i) begin
      wb_dat_o <= rd_mux;
    end
  end

  // control and divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `ASP_CTRL_RESET;
      div_r <= DEF_DIV;
    end else if (acc_wr) begin
      if (wb_adr_i == `ASP_OFF_CTRL && wb_sel_i[0]) begin
        ctrl_r <= wb_dat_i[7:0];
      end
      if (wb_adr_i == `ASP_OFF_BAUD) begin
        if (wb_sel_i[0]) begin
          div_r[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          div_r[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  // eight ticks per bit; a divider of 0 or 1 ticks every clock, the top rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (div_r <= 16'h0001 || cnt_r >= div_r - 16'h0001) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // transmit holding register; a write while full is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_hold_r <= 8'h00;
      tx_pend_r <= 1'b0;
    end else if (tx_take) begin
      tx_pend_r <= 1'b0;
    end else if (acc_wr && wb_adr_i == `ASP_OFF_DATA && wb_sel_i[0] && !tx_pend_r) begin
      tx_hold_r <= wb_dat_i[7:0];
      tx_pend_r <= 1'b1;
    end
  end

  // receive holding register; a new byte wins over the read that frees it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_data_r <= 8'h00;
      rx_valid_r <= 1'b0;
    end else if (rx_done) begin
      rx_data_r <= rx_byte;
      rx_valid_r <= 1'b1;
    end else if (acc_rd && wb_adr_i == `ASP_OFF_DATA) begin
      rx_valid_r <= 1'b0;
    end
  end

  assign cts_ok = (flow == asp_pkg::ASP_FLOW_NONE) || !cts_s;

  // modem outputs; in flow mode the request drops while a byte sits unread
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      send_request_n_o <= 1'b1;
      terminal_ready_n_o <= 1'b1;
      wake_o <= 1'b0;
    end else begin
      if (flow == asp_pkg::ASP_FLOW_RTSCTS) begin
        send_request_n_o <= rx_valid_r;
      end else begin
        send_request_n_o <= !ctrl_r[`ASP_CTRL_RTS];
      end
      terminal_ready_n_o <= !ctrl_r[`ASP_CTRL_DTR];
      wake_o <= ctrl_r[`ASP_CTRL_WAKE_EN] && !ring_s;
    end
  end

  // interrupt events
  always_comb begin
    irq_ev = 8'h00;
    irq_ev[`ASP_IRQ_RX_DONE] = rx_done;
    irq_ev[`ASP_IRQ_TX_DONE] = tx_done;
    irq_ev[`ASP_IRQ_PAR_ERR] = rx_done && rx_perr;
    irq_ev[`ASP_IRQ_FRM_ERR] = rx_done && rx_ferr;
    irq_ev[`ASP_IRQ_OVERRUN] = rx_done && rx_valid_r && !(acc_rd && wb_adr_i == `ASP_OFF_DATA);
    irq_ev[`ASP_IRQ_RING] = prev_r[3] && !ring_s;
    irq_ev[`ASP_IRQ_DCD_CHG] = prev_r[2] ^ dcd_s;
    irq_ev[`ASP_IRQ_CTS_CHG] = prev_r[1] ^ cts_s;
  end

  // a read clears only the bits it returned, so an event on that edge survives
  assign reg_sel = (acc_rd && wb_adr_i == `ASP_OFF_IRQ) ? wb_dat_o[7:0] : 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_r <= 8'h00;
      irq_mask_r <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~reg_sel) | irq_ev;
      if (acc_wr && wb_adr_i == `ASP_OFF_MASK && wb_sel_i[0]) begin
        irq_mask_r <= wb_dat_i[7:0];
      end
      irq_o <= |(((irq_st_r & ~reg_sel) | irq_ev) & irq_mask_r);
    end
  end

  asp_tx u_tx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick_r),
    .data_i(tx_hold_r),
    .pend_i(tx_pend_r),
    .cts_ok_i(cts_ok),
    .data8_i(ctrl_r[`ASP_CTRL_DATA8]),
    .par_en_i(ctrl_r[`ASP_CTRL_PAR_EN]),
    .par_odd_i(ctrl_r[`ASP_CTRL_PAR_ODD]),
    .stop2_i(ctrl_r[`ASP_CTRL_STOP2]),
    .take_o(tx_take),
    .done_o(tx_done),
    .busy_o(tx_busy),
    .txd_o(serial_out_o),
    .drv_en_o(line_driver_enable_o)
  );

  asp_rx u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick_r),
    .rxd_i(rxd_s),
    .data8_i(ctrl_r[`ASP_CTRL_DATA8]),
    .par_en_i(ctrl_r[`ASP_CTRL_PAR_EN]),
    .par_odd_i(ctrl_r[`ASP_CTRL_PAR_ODD]),
    .data_o(rx_byte),
    .done_o(rx_done),
    .par_err_o(rx_perr),
    .frm_err_o(rx_ferr)
  );
endmodule // asp_top

// ### sim/asp_checker.sv
/*
  pin and bus assertions for the serial port, bound into asp_top.
  assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/100ps
`include "asp_map.svh"
module asp_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic serial_out_o,
  input wire logic send_clear_n_i,
  input wire logic terminal_ready_n_o,
  input wire logic line_driver_enable_o
);
  logic flow_r;
  logic [7:0] hi_cnt_r;
  logic ctrl_wr;
  assign ctrl_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `ASP_OFF_CTRL;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // shadow of the flow bit, so the clear-to-send check knows when it applies
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flow_r <= 1'b1;
    end else if (ctrl_wr) begin
      flow_r <= wb_dat_i[`ASP_CTRL_FLOW];
    end
  end
  // saturating, so a long idle line cannot wrap to a short run
  always_ff @(posedge clk_i) begin
    if (rst_i || !serial_out_o) begin
      hi_cnt_r <= 8'h00;
    end else if (hi_cnt_r != 8'hff) begin
      hi_cnt_r <= hi_cnt_r + 8'h01;
    end
  end
  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_UNMAPPED_ZERO: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h14 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_DTR_FOLLOWS: assert property (ctrl_wr |-> ##2 terminal_ready_n_o == !$past(wb_dat_i[6], 2))
    else $error("terminal ready wrong");
  AST_IDLE_HIGH: assert property (!line_driver_enable_o |-> serial_out_o)
    else $error("line low with driver off");
  AST_LEAD: assert property ($rose(line_driver_enable_o) |-> serial_out_o [*8])
    else $error("start bit too early");
  AST_START_SOON: assert property ($rose(line_driver_enable_o) |-> ##[8:1000] !serial_out_o)
    else $error("no start bit");
  AST_BIT_MIN: assert property ($fell(serial_out_o) |-> !serial_out_o [*8])
    else $error("start bit too short");
  AST_TAIL: assert property ($fell(line_driver_enable_o) |-> hi_cnt_r >= 8'h0f)
    else $error("enable dropped early");
  AST_CTS_STOPS: assert property ((flow_r && send_clear_n_i) [*5] |-> !$rose(line_driver_enable_o))
    else $error("frame started while not clear");
  C_TX: cover property ($rose(line_driver_enable_o));
  C_RD: cover property (wb_ack_o && !wb_we_i);
  C_END: cover property ($fell(line_driver_enable_o));
endmodule // asp_checker

bind asp_top asp_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .serial_out_o(serial_out_o), .send_clear_n_i(send_clear_n_i),
  .terminal_ready_n_o(terminal_ready_n_o), .line_driver_enable_o(line_driver_enable_o));

// ### sim/asp_remote.sv
/*
  far-end serial device: sends frames to the port, collects frames from it.
  assumes bit length in clocks and frame format come from the bench.
*/
`timescale 1ns/100ps
module asp_remote (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic req_n_i,
  input wire logic hold_i,
  input wire logic [4:0] fmt_i,
  input wire logic [15:0] bit_clks_i,
  output logic line_o,
  output logic clear_n_o,
  output logic [9:0] got_o,
  output logic got_vld_o
);
  function automatic logic slot(input int i);
    return i < (fmt_i[0] ? 8 : 7) || (i == 8 && fmt_i[1]) || i == 9 || (i == 10 && fmt_i[3]);
  endfunction
  initial begin
    line_o = 1'b1;
    clear_n_o = 1'b0;
    got_vld_o = 1'b0;
    got_o = 10'h000;
  end
  always @(posedge clk_i) clear_n_o <= hold_i;
  // samples at mid-bit; slot 7 stays zero in seven-bit frames
  initial begin
    logic [9:0] v;
    forever begin
      @(negedge line_i);
      repeat (bit_clks_i / 2) @(posedge clk_i);
      v = 10'h000;
      for (int i = 0; i < 10; i++) begin
        if (slot(i)) begin
          repeat (bit_clks_i) @(posedge clk_i);
          v[i] = line_i;
        end
      end
      got_o <= v;
      got_vld_o <= 1'b1;
      @(posedge clk_i);
      got_vld_o <= 1'b0;
    end
  end
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic p;
    p = ^(d & {fmt_i[0], 7'h7f}) ^ fmt_i[2] ^ bad_par;
    while (fmt_i[4] && req_n_i) @(posedge clk_i);
    line_o <= 1'b0;
    repeat (bit_clks_i) @(posedge clk_i);
    for (int i = 0; i < 11; i++) begin
      if (slot(i)) begin
        line_o <= i < 8 ? d[i] : i == 8 ? p : !(i == 9 && bad_stop);
        repeat (bit_clks_i) @(posedge clk_i);
      end
    end
    line_o <= 1'b1;
  endtask
endmodule // asp_remote

// ### sim/asp_top_bench.sv
/*
  self-checking bench of the serial port with a far-end model and result queues.
  assumes asp_remote and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
`include "asp_map.svh"
module asp_top_bench;
  localparam int T = 16;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rx_line, tx_line, rts_n, cts_n, dtr_n, lde, irq, wake, got_v;
  logic dcd_n = 1'b1;
  logic ring_n = 1'b1;
  logic hold = 1'b0;
  logic [7:0] fmt = 8'h11;
  logic [9:0] got;
  logic [31:0] en_cnt = 32'h0;
  logic lead_on = 1'b1;
  logic [31:0] rd_exp[$], rd_msk[$], tx_exp[$];
  int en_exp[$];
  int n_mismatch = 0;
  int tests_run = 0;

  asp_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .serial_in_i(rx_line), .serial_out_o(tx_line), .send_request_n_o(rts_n), .send_clear_n_i(cts_n),
    .terminal_ready_n_o(dtr_n), .carrier_detect_n_i(dcd_n), .ring_indicate_n_i(ring_n),
    .line_driver_enable_o(lde), .irq_o(irq), .wake_o(wake));
  asp_remote i_rem (.clk_i(clk_i), .line_i(tx_line), .req_n_i(rts_n), .hold_i(hold), .fmt_i(fmt[4:0]),
    .bit_clks_i(16'(T)), .line_o(rx_line), .clear_n_o(cts_n), .got_o(got), .got_vld_o(got_v));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  function automatic int bits(input logic [7:0] f);
    return 9 + f[0] + f[1] + f[3];
  endfunction
  function automatic logic [31:0] frame(input logic [7:0] f, input logic [7:0] d);
    logic [7:0] m;
    m = f[0] ? d : {1'b0, d[6:0]};
    return {22'h0, 1'b1, f[1] & (^m ^ f[2]), m};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    // no cycle count assumed here: only the watchdog ends a hung access
    do begin
      @(posedge clk_i);
    end while (!wb_ack_o);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd_exp.push_back(e & m);
    rd_msk.push_back(m);
    wb(1'b0, a, 32'h0);
  endtask
  // n bytes back to back keep the enable up across all n frames
  task automatic tx_case(input logic [7:0] f, input int n);
    logic [7:0] d;
    fmt <= f;
    wb(1'b1, `ASP_OFF_CTRL, f);
    en_exp.push_back((n * bits(f) + 2) * T);
    repeat (n) begin
      d = $urandom;
      tx_exp.push_back(frame(f, d));
      wb(1'b1, `ASP_OFF_DATA, d);
      repeat (4) @(posedge clk_i);
    end
    repeat ((n * bits(f) + 4) * T) @(posedge clk_i);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    if (wb_ack_o && !wb_we_i) check("read", wb_dat_o & rd_msk.pop_front(), rd_exp.pop_front());
    if (got_v) check("frame", {22'h0, got}, tx_exp.pop_front());
    en_cnt <= lde ? en_cnt + 1 : 32'h0;
    lead_on <= !lde || (lead_on && tx_line);
    if (lde && lead_on && !tx_line) check("lead", en_cnt, T);
    if (!lde && en_cnt != 0) check("drv_en span", en_cnt, en_exp.pop_front());
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    logic [7:0] d, f;
    void'($urandom(67));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("dtr_n", dtr_n, 1'b1);
    rd(`ASP_OFF_CTRL, 32'h11, 32'hff);
    rd(`ASP_OFF_BAUD, `ASP_DEF_DIV, 32'hffff);
    rd(8'h20, 32'h0, 32'hffffffff);
    wb(1'b1, `ASP_OFF_BAUD, T / 8);
    for (int i = 0; i < 16; i++) begin
      wb(1'b1, `ASP_OFF_MASK, {30'h0, i[2], 1'b0});
      tx_case(8'h10 | 8'(i), 1 + i[0]);
      check("irq", irq, i[2]);
      rd(`ASP_OFF_IRQ, 32'h2, 32'h2);
      repeat (2) @(posedge clk_i);
      check("irq", irq, 1'b0);
    end
    hold <= 1'b1;
    repeat (4) @(posedge clk_i);
    fork
      tx_case(8'h11, 1);
      begin
        repeat (40) @(posedge clk_i);
        check("held", lde, 1'b0);
        hold <= 1'b0;
      end
    join
    repeat (4 * T) @(posedge clk_i);
    hold <= 1'b1;
    tx_case(8'h61, 1);
    check("rts_n", rts_n, 1'b0);
    check("dtr_n", dtr_n, 1'b0);
    hold <= 1'b0;
    wb(1'b1, `ASP_OFF_MASK, 32'h1);
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      f = i == 0 ? 8'h13 : i == 1 ? 8'h17 : 8'h10;
      fmt <= f;
      wb(1'b1, `ASP_OFF_CTRL, f);
      i_rem.send(d, i == 1, i == 2);
      repeat (4) @(posedge clk_i);
      check("rts_n", rts_n, 1'b1);
      check("irq", irq, 1'b1);
      rd(`ASP_OFF_IRQ, {28'h0, i == 2, i == 1, 2'b01}, 32'h1d);
      rd(`ASP_OFF_DATA, frame(f, d), 32'hff);
      repeat (2) @(posedge clk_i);
      check("rts_n", rts_n, 1'b0);
    end
    dcd_n <= 1'b0;
    ring_n <= 1'b0;
    wb(1'b1, `ASP_OFF_CTRL, 32'h91);
    repeat (4) @(posedge clk_i);
    check("wake", wake, 1'b1);
    rd(`ASP_OFF_STAT, 32'h18, 32'h18);
    rd(`ASP_OFF_IRQ, 32'h60, 32'h60);
    wb(1'b1, `ASP_OFF_CTRL, 32'h11);
    repeat (3) @(posedge clk_i);
    check("wake", wake, 1'b0);
    print_verdict();
  end
endmodule // asp_top_bench
